//--- hdl/wake_pkg.sv
// package for the wake event status block: offsets, reset values, field positions, carriers
// assumes a byte-wide register port decoded against a programmed base address
package wake_pkg;
	// ************************************************************
	// register offsets from the runtime block base
	// ************************************************************
	localparam logic [7:0] OFS_PIN_STATUS = 8'h00;
	localparam logic [7:0] OFS_PIN_ENABLE = 8'h02;
	localparam logic [7:0] OFS_SRC_STATUS_A = 8'h04;
	localparam logic [7:0] OFS_SRC_STATUS_B = 8'h05;
	localparam logic [7:0] OFS_GPIO_STATUS = 8'h06;
	localparam logic [7:0] OFS_POWER_STATUS = 8'h07;
	localparam logic [7:0] OFS_SRC_ENABLE_A = 8'h08;
	localparam logic [7:0] OFS_SRC_ENABLE_B = 8'h09;
	localparam logic [7:0] OFS_GPIO_ENABLE = 8'h0A;
	localparam logic [7:0] OFS_POWER_ENABLE = 8'h0B;
	// ************************************************************
	// reset values and field layouts
	// ************************************************************
	localparam logic [7:0] STANDBY_RESET_VALUE = 8'h00;
	localparam int SUMMARY_FLAG_BIT = 0;
	localparam int OUTPUT_ENABLE_BIT = 0;
	localparam int LOW_BATTERY_BIT = 0;
	localparam logic [7:0] MASK_PIN = 8'h01;
	localparam logic [7:0] MASK_SRC_A = 8'h5F;
	localparam logic [7:0] MASK_SRC_B = 8'h7F;
	localparam logic [7:0] MASK_GPIO = 8'hFF;
	localparam logic [7:0] MASK_POWER = 8'hFD;
	localparam logic [7:0] READ_IDLE = 8'h00;
	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
	typedef struct packed {
		logic hardware_monitor_wake;
		logic ring_indicator_two_wake;
		logic ring_indicator_one_wake;
		logic keyboard_wake;
		logic mouse_wake;
		logic infrared_receive_pin;
		logic watchdog_wake;
		logic gpio_21_wake;
		logic gpio_22_wake;
		logic grouped_smi_wake;
		logic gpio_27_wake;
		logic gpio_32_wake;
		logic gpio_33_wake;
		logic [7:0] gpio_50_wake;
		logic gpio_60_wake;
		logic gpio_61_wake;
		logic specific_mouse_click_wake;
		logic power_button_wake;
		logic power_failure_recovery_flag;
	} wake_src_t;
	typedef struct packed {
		logic standby_por;
		logic main_por;
		logic battery_replaced_or_below_1v2;
		logic battery_below_2v4;
	} power_evt_t;
endpackage : wake_pkg

//--- hdl/wake_event_status_logic.sv
// wake event status logic: sticky wake status, enables and active-low wake request pin
// assumes wake sources and power events are synchronous pulses/levels in the clock domain,
// except the infrared receive pin which is a raw pin and is synchronised here
// How it works
// - summary flag sets whenever an enabled source would request wake, ignoring output enable
// - writing 1 clears summary flag and releases pin; writing 0 does nothing
// - summary flag survives main POR, soft and bus resets; standby POR clears it
// - output enable bit 0 blocks pin when 0, allows pin when 1
// - output enable survives other resets, cleared only by standby POR
// - source status bits record events regardless of any enable
// - set status bit with matching enable requests the wake pin
// - status A: monitor, ring two, ring one, keyboard, mouse, bit 6 infrared edge
// - status B: watchdog, gpio21, gpio22, grouped smi, gpio27, gpio32, gpio33
// - gpio status bits 0..7 map gpio 50..57
// - writing 1 clears a status bit, writing 0 leaves it
// - source status registers cleared only on standby POR
// - low battery flag set at standby POR on battery replace or below 1.2V
// - low battery flag set at main POR when battery dropped below 2.4V
// - low battery needs its enable to request wake and is no wakeup event
// - power status: gpio60 bit2, gpio61 bit3, mouse click bit4, button bit6, recovery bit7
// - power status ignores other resets, cleared by writing 1
// - registers decoded at fixed byte offsets from programmed base
// - enable 0 keeps status recording but blocks the pin
`timescale 1ns/1ns
`default_nettype none
module wake_event_status_logic (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] wake_runtime_block_base,
	input wire wake_pkg::reg_req_t req,
	output logic [7:0] rdata,
	input wire wake_pkg::wake_src_t src,
	input wire wake_pkg::power_evt_t pwr,
	output logic wake_request_pin_n
);
	// ************************************************************
	// decode
	// ************************************************************
	logic [7:0] offset;
	logic [7:0] pin_status_reg;
	logic [7:0] pin_enable_reg;
	logic [7:0] src_status_a_reg;
	logic [7:0] src_status_b_reg;
	logic [7:0] gpio_status_reg;
	logic [7:0] power_status_reg;
	logic [7:0] src_enable_a_reg;
	logic [7:0] src_enable_b_reg;
	logic [7:0] gpio_enable_reg;
	logic [7:0] power_enable_reg;
	logic [7:0] set_a;
	logic [7:0] set_b;
	logic [7:0] set_g;
	logic [7:0] set_p;
	logic ir_sync1_reg;
	logic ir_sync2_reg;
	logic ir_last_reg;
	logic any_request;
	logic [7:0] rdata_next;
	logic hit_pin_status;
	logic hit_pin_enable;
	logic hit_src_status_a;
	logic hit_src_status_b;
	logic hit_gpio_status;
	logic hit_power_status;
	logic hit_src_enable_a;
	logic hit_src_enable_b;
	logic hit_gpio_enable;
	logic hit_power_enable;

	assign offset = 8'(req.addr - wake_runtime_block_base);

	// write strobes, one per register
	assign hit_pin_status = req.wr && (offset == wake_pkg::OFS_PIN_STATUS);
	assign hit_pin_enable = req.wr && (offset == wake_pkg::OFS_PIN_ENABLE);
	assign hit_src_status_a = req.wr && (offset == wake_pkg::OFS_SRC_STATUS_A);
	assign hit_src_status_b = req.wr && (offset == wake_pkg::OFS_SRC_STATUS_B);
	assign hit_gpio_status = req.wr && (offset == wake_pkg::OFS_GPIO_STATUS);
	assign hit_power_status = req.wr && (offset == wake_pkg::OFS_POWER_STATUS);
	assign hit_src_enable_a = req.wr && (offset == wake_pkg::OFS_SRC_ENABLE_A);
	assign hit_src_enable_b = req.wr && (offset == wake_pkg::OFS_SRC_ENABLE_B);
	assign hit_gpio_enable = req.wr && (offset == wake_pkg::OFS_GPIO_ENABLE);
	assign hit_power_enable = req.wr && (offset == wake_pkg::OFS_POWER_ENABLE);

	// ************************************************************
	// infrared pin synchroniser and edge
	// ************************************************************
	// chain starts at the idle low level, no false edge after reset
	// limitation: a pin already high at standby release counts as one edge
	always_ff @(posedge clock) begin
		if (pwr.standby_por) begin
			ir_sync1_reg <= 1'b0;
			ir_sync2_reg <= 1'b0;
			ir_last_reg <= 1'b0;
		end else begin
			ir_sync1_reg <= src.infrared_receive_pin;
			ir_sync2_reg <= ir_sync1_reg;
			ir_last_reg <= ir_sync2_reg;
		end
	end

	// ************************************************************
	// event mapping
	// ************************************************************
	// status A layout, infrared on any edge
	assign set_a = {1'b0, ir_sync2_reg ^ ir_last_reg, 1'b0, src.mouse_wake,
		src.keyboard_wake, src.ring_indicator_one_wake, src.ring_indicator_two_wake,
		src.hardware_monitor_wake};
	assign set_b = {1'b0, src.gpio_33_wake, src.gpio_32_wake, src.gpio_27_wake,
		src.grouped_smi_wake, src.gpio_22_wake, src.gpio_21_wake, src.watchdog_wake};
	assign set_g = src.gpio_50_wake;
	// power status layout; low battery latched at main por
	assign set_p = {src.power_failure_recovery_flag, src.power_button_wake, 1'b0,
		src.specific_mouse_click_wake, src.gpio_61_wake, src.gpio_60_wake, 1'b0,
		pwr.main_por && pwr.battery_below_2v4};

	// ************************************************************
	// status registers
	// ************************************************************
	// srst is the main, soft and bus reset: it never reaches these, only standby por does
	// status A records events, write-one clear
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_SRC_A),
		.CLEAR_ON_ONE(1'b1)
	) u_src_status_a (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_src_status_a),
		.wdata(req.wdata),
		.set_bits(set_a),
		.value_reg(src_status_a_reg)
	);

	// status B, reserved bit held at zero
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_SRC_B),
		.CLEAR_ON_ONE(1'b1)
	) u_src_status_b (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_src_status_b),
		.wdata(req.wdata),
		.set_bits(set_b),
		.value_reg(src_status_b_reg)
	);

	// gpio status, all eight bits live
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_GPIO),
		.CLEAR_ON_ONE(1'b1)
	) u_gpio_status (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_gpio_status),
		.wdata(req.wdata),
		.set_bits(set_g),
		.value_reg(gpio_status_reg)
	);

	// power status, low battery loaded at standby por
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_POWER),
		.CLEAR_ON_ONE(1'b1)
	) u_power_status (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value({7'h00, pwr.battery_replaced_or_below_1v2}),
		.hit(hit_power_status),
		.wdata(req.wdata),
		.set_bits(set_p),
		.value_reg(power_status_reg)
	);

	// ************************************************************
	// enable registers
	// ************************************************************
	// output enable, standby por only
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_PIN),
		.CLEAR_ON_ONE(1'b0)
	) u_pin_enable (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_pin_enable),
		.wdata(req.wdata),
		.set_bits(8'h00),
		.value_reg(pin_enable_reg)
	);

	wake_reg_byte #(
		.MASK(wake_pkg::MASK_SRC_A),
		.CLEAR_ON_ONE(1'b0)
	) u_src_enable_a (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_src_enable_a),
		.wdata(req.wdata),
		.set_bits(8'h00),
		.value_reg(src_enable_a_reg)
	);

	wake_reg_byte #(
		.MASK(wake_pkg::MASK_SRC_B),
		.CLEAR_ON_ONE(1'b0)
	) u_src_enable_b (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_src_enable_b),
		.wdata(req.wdata),
		.set_bits(8'h00),
		.value_reg(src_enable_b_reg)
	);

	wake_reg_byte #(
		.MASK(wake_pkg::MASK_GPIO),
		.CLEAR_ON_ONE(1'b0)
	) u_gpio_enable (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_gpio_enable),
		.wdata(req.wdata),
		.set_bits(8'h00),
		.value_reg(gpio_enable_reg)
	);

	// power enables, low battery needs its bit
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_POWER),
		.CLEAR_ON_ONE(1'b0)
	) u_power_enable (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_power_enable),
		.wdata(req.wdata),
		.set_bits(8'h00),
		.value_reg(power_enable_reg)
	);

	// status gated by its own enable
	assign any_request = |(src_status_a_reg & src_enable_a_reg)
		|| |(src_status_b_reg & src_enable_b_reg)
		|| |(gpio_status_reg & gpio_enable_reg)
		|| |(power_status_reg & power_enable_reg);

	// ************************************************************
	// summary flag and pin
	// ************************************************************
	// set by enabled requests, w1c, standby por only
	// a request still standing re-sets the flag, so clear the source first
	wake_reg_byte #(
		.MASK(wake_pkg::MASK_PIN),
		.CLEAR_ON_ONE(1'b1)
	) u_pin_status (
		.clock(clock),
		.standby_por(pwr.standby_por),
		.standby_value(wake_pkg::STANDBY_RESET_VALUE),
		.hit(hit_pin_status),
		.wdata(req.wdata),
		.set_bits({7'h00, any_request}),
		.value_reg(pin_status_reg)
	);

	// drive low only with enable and flag
	always_ff @(posedge clock) begin
		if (srst || pwr.standby_por)
			wake_request_pin_n <= 1'b1;
		else
			wake_request_pin_n <= ~(pin_enable_reg[wake_pkg::OUTPUT_ENABLE_BIT]
				&& pin_status_reg[wake_pkg::SUMMARY_FLAG_BIT]);
	end

	// ************************************************************
	// read path
	// ************************************************************
	// unmapped and reserved read zero
	always_comb begin
		rdata_next = wake_pkg::READ_IDLE;
		if (req.rd) begin
			case (offset)
				wake_pkg::OFS_PIN_STATUS: rdata_next = pin_status_reg;
				wake_pkg::OFS_PIN_ENABLE: rdata_next = pin_enable_reg;
				wake_pkg::OFS_SRC_STATUS_A: rdata_next = src_status_a_reg;
				wake_pkg::OFS_SRC_STATUS_B: rdata_next = src_status_b_reg;
				wake_pkg::OFS_GPIO_STATUS: rdata_next = gpio_status_reg;
				wake_pkg::OFS_POWER_STATUS: rdata_next = power_status_reg;
				wake_pkg::OFS_SRC_ENABLE_A: rdata_next = src_enable_a_reg;
				wake_pkg::OFS_SRC_ENABLE_B: rdata_next = src_enable_b_reg;
				wake_pkg::OFS_GPIO_ENABLE: rdata_next = gpio_enable_reg;
				wake_pkg::OFS_POWER_ENABLE: rdata_next = power_enable_reg;
				default: rdata_next = wake_pkg::READ_IDLE;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst)
			rdata <= wake_pkg::READ_IDLE;
		else
			rdata <= rdata_next;
	end
endmodule : wake_event_status_logic

// ************************************************************
// one register byte: write-one-clear status or plain read/write enable
// ************************************************************
// only standby por resets it; event bits win over a clear in the same cycle
module wake_reg_byte #(
	parameter logic [7:0] MASK = 8'hFF,
	parameter bit CLEAR_ON_ONE = 1'b1
) (
	input wire logic clock,
	input wire logic standby_por,
	input wire logic [7:0] standby_value,
	input wire logic hit,
	input wire logic [7:0] wdata,
	input wire logic [7:0] set_bits,
	output logic [7:0] value_reg
);
	logic [7:0] value_next;

	// clear on one or plain write, reserved bits held at zero
	always_comb begin
		value_next = value_reg;
		if (hit) begin
			if (CLEAR_ON_ONE)
				value_next = value_reg & ~wdata;
			else
				value_next = wdata;
		end
		value_next = (value_next | set_bits) & MASK;
	end

	// only the standby reset reaches this byte
	always_ff @(posedge clock) begin
		if (standby_por)
			value_reg <= standby_value & MASK;
		else
			value_reg <= value_next;
	end
endmodule : wake_reg_byte
`default_nettype wire

//--- dv/wake_sva.sv
// port checker for the wake event status block
// assumes it is bound to the top module, one clock domain
`timescale 1ns/1ns
`default_nettype none
module wake_sva (
	input wire logic clock,
	input wire logic srst,
	input wire logic [7:0] wake_runtime_block_base,
	input wire wake_pkg::reg_req_t req,
	input wire logic [7:0] rdata,
	input wire wake_pkg::power_evt_t pwr,
	input wire logic wake_request_pin_n
);
	logic [7:0] ofs;
	// offset wraps like the decoder does
	assign ofs = req.addr - wake_runtime_block_base;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	AST_RD_IDLE: assert property (!req.rd |=> rdata == 8'h00)
		else $error("read data not idle");
	AST_RSV_PIN: assert property (req.rd && ofs == 8'h00 |=> rdata[7:1] == 7'h00)
		else $error("pin status reserved bits");
	AST_RSV_A: assert property (req.rd && ofs == 8'h04 |=> !rdata[7] && !rdata[5])
		else $error("status a reserved bits");
	AST_RSV_PWR: assert property (req.rd && ofs == 8'h07 |=> !rdata[1])
		else $error("power status bit 1 set");
	AST_UNMAPPED: assert property (req.rd && ofs == 8'h03 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_PIN_SRST: assert property ($fell(srst) |-> wake_request_pin_n)
		else $error("pin low after reset");
	AST_STANDBY: assert property (pwr.standby_por |-> ##2 wake_request_pin_n)
		else $error("pin low after standby reset");
	AST_PIN_OFF: assert property (req.wr && ofs == 8'h02 && !req.wdata[0] |-> ##2 wake_request_pin_n)
		else $error("pin low while disabled");
endmodule : wake_sva
bind wake_event_status_logic wake_sva u_sva (.clock(clock), .srst(srst),
	.wake_runtime_block_base(wake_runtime_block_base), .req(req), .rdata(rdata),
	.pwr(pwr), .wake_request_pin_n(wake_request_pin_n));
`default_nettype wire

//--- dv/wake_host_model.sv
// host side: counts cycles with the wake request asserted
// assumes the pin is active low, sampled on the rising clock
`timescale 1ns/1ns
`default_nettype none
module wake_host_model (
	input wire logic clock,
	input wire logic wake_request_pin_n,
	output var int wake_seen
);
	initial wake_seen = 0;
	always @(posedge clock) if (wake_request_pin_n === 1'b0) wake_seen <= wake_seen + 1;
endmodule : wake_host_model
`default_nettype wire

//--- dv/wake_event_status_logic_bench.sv
// bench with a behavioural register model
// assumes the package and host model are compiled first
`timescale 1ns/1ns
`default_nettype none
module wake_event_status_logic_bench;
	// ************************************************************
	// model and stimulus
	// ************************************************************
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic [7:0] base = 8'h00;
	logic [7:0] rdata;
	logic pin_n;
	wake_pkg::reg_req_t req = '0;
	wake_pkg::wake_src_t src = '0;
	wake_pkg::power_evt_t pwr = 4'h8;
	int n_errors = 0;
	int tests_run = 0;
	int seen;
	logic [31:0] rng = 32'h00009850;
	logic [7:0] m [12];
	logic [7:0] mask [12] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h5F, 8'h7F, 8'hFF, 8'hFD,
		8'h5F, 8'h7F, 8'hFF, 8'hFD};
	// offset*8+bit per source; infrared is edge driven, handled apart
	int tgt [26] = '{63, 62, 60, 59, 58, 48, 49, 50, 51, 52, 53, 54, 55, 46, 45, 44, 43,
		42, 41, 40, -1, 36, 35, 34, 33, 32};
	wake_event_status_logic u_dut (.clock(clock), .srst(srst), .wake_runtime_block_base(base),
		.req(req), .rdata(rdata), .src(src), .pwr(pwr), .wake_request_pin_n(pin_n));
	wake_host_model u_host (.clock(clock), .wake_request_pin_n(pin_n), .wake_seen(seen));
	initial forever #10 clock = ~clock;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic upd();
		if ((m[4] & m[8]) | (m[5] & m[9]) | (m[6] & m[10]) | (m[7] & m[11])) m[0] = 8'h01;
	endtask : upd
	task automatic wr(input int o, input logic [7:0] d);
		@(negedge clock);
		req = '{1'b0, 1'b1, base + 8'(o), d};
		@(negedge clock);
		req.wr = 1'b0;
		if (o inside {0, 4, 5, 6, 7}) m[o] &= ~d;
		else if (o == 2 || o > 7) m[o] = d & mask[o];
		upd();
	endtask : wr
	task automatic rd(input int o);
		@(negedge clock);
		req = '{1'b1, 1'b0, base + 8'(o), 8'h00};
		@(negedge clock);
		req.rd = 1'b0;
		chk(rdata, m[o]);
	endtask : rd
	task automatic pin();
		repeat (4) @(negedge clock);
		chk({7'h00, pin_n}, {7'h00, ~(m[2][0] & m[0][0])});
	endtask : pin
	task automatic pulse(input wake_pkg::wake_src_t s);
		@(negedge clock);
		src = s;
		@(negedge clock);
		src = '0;
		repeat (4) @(negedge clock);
	endtask : pulse
	task automatic ev(input int k);
		pulse(wake_pkg::wake_src_t'(26'h1 << k));
		m[tgt[k] / 8][tgt[k] % 8] = 1'b1;
		upd();
	endtask : ev
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// hang guard, nearly thirty times the expected run
	initial begin
		#400000;
		n_errors++;
		close_out();
	end
	initial begin
		rng = xs(rng);
		base = rng[7:0];
		foreach (m[i]) m[i] = 8'h00;
		repeat (2) @(negedge clock);
		srst = 1'b0;
		pwr = '0;
		for (int o = 0; o < 8; o++) rd(o);
		for (int k = 0; k < 26; k++) begin
			if (tgt[k] < 0) continue;
			ev(k);
			wr(tgt[k] / 8, 8'h00);
			rd(tgt[k] / 8);
			wr(tgt[k] / 8, 8'hFF);
			rd(tgt[k] / 8);
		end
		for (int i = 0; i < 2; i++) begin
			src.infrared_receive_pin = ~src.infrared_receive_pin;
			repeat (5) @(negedge clock);
			m[4][6] = 1'b1;
			rd(4);
			wr(4, 8'h40);
		end
		rd(0);
		wr(9, 8'h7F);
		ev(19);
		rd(0);
		pin();
		wr(2, 8'h01);
		pin();
		wr(0, 8'h01);
		pin();
		wr(5, 8'hFF);
		wr(0, 8'h01);
		pin();
		ev(19);
		srst = 1'b1;
		@(negedge clock);
		srst = 1'b0;
		pin();
		for (int o = 0; o < 12; o++) rd(o);
		wr(5, 8'hFF);
		wr(0, 8'h01);
		wr(9, 8'h00);
		ev(19);
		pin();
		wr(2, 8'h00);
		pwr = 4'h5;
		@(negedge clock);
		pwr = 4'h0;
		m[7][0] = 1'b1;
		pin();
		rd(7);
		wr(11, 8'h01);
		wr(2, 8'h01);
		pin();
		pwr = 4'hA;
		@(negedge clock);
		pwr = 4'h0;
		foreach (m[i]) m[i] = 8'h00;
		m[7] = 8'h01;
		pin();
		for (int o = 0; o < 12; o++) rd(o);
		wr(2, 8'h01);
		for (int i = 0; i < 8; i++) begin
			rng = xs(rng);
			wr(10, rng[7:0]);
			pulse(wake_pkg::wake_src_t'({13'h0000, rng[15:8], 5'h00}));
			m[6] |= rng[15:8];
			upd();
			pin();
			rd(6);
			rd(0);
			wr(6, 8'hFF);
			wr(0, 8'h01);
		end
		wr(8, 8'hFF);
		rd(8);
		ev(22);
		rd(0);
		pin();
		chk(8'(seen > 0), 8'h01);
		close_out();
	end
endmodule : wake_event_status_logic_bench
`default_nettype wire
